//--- fpd_regs.vh
/*
 Constants for the flash command front end: opcodes, configuration bit
 positions and protection geometry. Definitions only; included by the
 design files of the block.
*/
`ifndef FPD_REGS_VH
`define FPD_REGS_VH

// Configuration and status bit positions
`define FPD_CFG1NV_TB_BIT     5
`define FPD_CFG2V_ALEN_BIT    0
`define FPD_CFG2NV_ALEN_BIT   1
`define FPD_STAT1NV_SPM_BIT   7

// Array geometry: 64 MB, protection granule is one 1 MB sector
`define FPD_ARRAY_MSB         25
`define FPD_GRAN_LSB          20

// Address field lengths in bits
`define FPD_ADDR_BITS_3B      6'd24
`define FPD_ADDR_BITS_4B      6'd32

// Dummy clock cycles before read data on fast and quad reads
`define FPD_DUMMY_CYC         6'd8

// Opcodes that always take a four byte address
`define FPD_OP_READ_W         8'h13
`define FPD_OP_FREAD_W        8'h0c
`define FPD_OP_QOREAD_W       8'h6c
`define FPD_OP_QIOREAD_W      8'hec
`define FPD_OP_ECCREAD_W      8'h18
`define FPD_OP_PPROG_W        8'h12
`define FPD_OP_PSCRUB_W       8'hcf
`define FPD_OP_QPROG_W        8'h34
`define FPD_OP_SERASE_W       8'h21
`define FPD_OP_BERASE_W       8'hdc

// Opcodes whose address length follows the address-length mode
`define FPD_OP_READ_L         8'h03
`define FPD_OP_FREAD_L        8'h0b
`define FPD_OP_QOREAD_L       8'h6b
`define FPD_OP_QIOREAD_L      8'heb
`define FPD_OP_PPROG_L        8'h02
`define FPD_OP_QPROG_L        8'h32
`define FPD_OP_SERASE_L       8'h20
`define FPD_OP_BERASE_L       8'hd8
`define FPD_OP_RDANY_L        8'h65
`define FPD_OP_WRANY_L        8'h71

// Address-length mode enter and exit
`define FPD_OP_ALEN_ENTER     8'hb7
`define FPD_OP_ALEN_EXIT      8'he9

// Command record layout in the buffer
`define FPD_REC_W             42
`define FPD_REC_READ_BIT      41
`define FPD_REC_WIDE_BIT      40

`endif

//--- fpd_buf2.v
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock, asynchronous active-low reset; out_data and out_valid are registers, in_ready decodes the count.
*/
`timescale 1ns/100ps
`default_nettype none

module fpd_buf2 #(
   parameter W = 42
) (
   input  wire         mclk,
   input  wire         arst_n,
   input  wire [W-1:0] in_data,
   input  wire         in_valid,
   output wire         in_ready,
   output wire [W-1:0] out_data,
   output wire         out_valid,
   input  wire         out_ready
);

   reg [W-1:0] ent_ff [0:1];
   reg         rd_ptr_ff;
   reg         wr_ptr_ff;
   reg [1:0]   cnt_ff;
   reg [W-1:0] out_data_ff;
   reg         out_valid_ff;

   wire push = in_valid & (cnt_ff != 2'd2);
   wire pop  = (cnt_ff != 2'd0) & (~out_valid_ff | out_ready);

   assign in_ready  = (cnt_ff != 2'd2);
   assign out_data  = out_data_ff;
   assign out_valid = out_valid_ff;

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rd_ptr_ff    <= 1'b0;
         wr_ptr_ff    <= 1'b0;
         cnt_ff       <= 2'd0;
         out_data_ff  <= {W{1'b0}};
         out_valid_ff <= 1'b0;
      end else begin
         if (push) begin
            ent_ff[wr_ptr_ff] <= in_data;
            wr_ptr_ff         <= ~wr_ptr_ff;
         end
         if (pop) begin
            out_data_ff <= ent_ff[rd_ptr_ff];
            rd_ptr_ff   <= ~rd_ptr_ff;
         end
         if (pop)
            out_valid_ff <= 1'b1;
         else if (out_ready)
            out_valid_ff <= 1'b0;
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule // fpd_buf2

`default_nettype wire

//--- fpd_front.v
/*
 Serial flash command front end: frames commands by chip select, picks
 3- or 4-byte address fields, applies legacy block protection and hands
 command records to the array side through a two-entry buffer.
 Assumes pins arrive asynchronously and the serial clock is at most an
 eighth of mclk; SPI mode 0. Status and configuration bits come from the
 register logic on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fpd_regs.vh"

module fpd_front (
   input  wire                 mclk,
   input  wire                 arst_n,
   input  wire                 cs_n_pin,
   input  wire                 sck_pin,
   input  wire [3:0]           io_in,
   output wire [3:0]           io_out,
   output wire [3:0]           io_oe,
   input  wire                 protect_range_bit2,
   input  wire                 protect_range_bit1,
   input  wire                 protect_range_bit0,
   input  wire [7:0]           config1_nonvol,
   input  wire [7:0]           config2_nonvol,
   input  wire [7:0]           status1_nonvol,
   input  wire                 sw_reset,
   output wire [7:0]           config2_volatile,
   output wire                 protect_from_bottom_sel,
   output wire                 protect_mode_selector,
   output wire                 cmd_valid,
   input  wire                 cmd_ready,
   output wire [7:0]           cmd_opcode,
   output wire [31:0]          cmd_addr,
   output wire                 cmd_read,
   output wire                 cmd_wide,
   input  wire [7:0]           rd_data,
   output wire                 rd_next,
   output wire                 prot_block,
   output wire                 frame_reject
);

   localparam ST_IDLE  = 3'd0;
   localparam ST_OPC   = 3'd1;
   localparam ST_ADDR  = 3'd2;
   localparam ST_DUMMY = 3'd3;
   localparam ST_DOUT  = 3'd4;
   localparam ST_DIN   = 3'd5;

   // Two-stage synchronisers for all pins
   reg  [5:0]  sync1_ff;
   reg  [5:0]  sync2_ff;
   reg         sck_d_ff;
   reg         cs_d_ff;
   wire        cs_s  = sync2_ff[5];
   wire        sck_s = sync2_ff[4];
   wire [3:0]  io_s  = sync2_ff[3:0];
   wire        sck_rise = sck_s & ~sck_d_ff & ~cs_s;
   wire        sck_fall = ~sck_s & sck_d_ff & ~cs_s;
   wire        cs_end   = cs_s & ~cs_d_ff;
   wire        cs_start = ~cs_s & cs_d_ff;

   reg  [2:0]  st_ff;
   reg  [7:0]  opc_ff;
   reg  [31:0] sh_ff;
   reg  [31:0] addr_ff;
   reg  [5:0]  cnt_ff;
   reg  [2:0]  bmod_ff;
   reg         addr_done_ff;
   reg         wide_ff;
   reg  [7:0]  out_sh_ff;
   reg  [2:0]  out_cnt_ff;
   reg  [3:0]  io_out_ff;
   reg  [3:0]  io_oe_ff;
   reg         rd_next_ff;
   reg         prot_block_ff;
   reg         frame_reject_ff;
   reg         alen_ff;
   reg         tb_ff;
   reg         spm_ff;
   reg         load_pend_ff;
   reg  [`FPD_REC_W-1:0] pend_rec_ff;
   reg         pend_ff;

   wire [7:0]  opc_nxt = {sh_ff[6:0], io_s[0]};

   // Opcode classes for the opcode being decoded or held
   function is_wide_op;
      input [7:0] op;
      begin
         case (op)
            `FPD_OP_READ_W, `FPD_OP_FREAD_W, `FPD_OP_QOREAD_W, `FPD_OP_QIOREAD_W,
            `FPD_OP_ECCREAD_W, `FPD_OP_PPROG_W, `FPD_OP_PSCRUB_W, `FPD_OP_QPROG_W,
            `FPD_OP_SERASE_W, `FPD_OP_BERASE_W: is_wide_op = 1'b1;
            default: is_wide_op = 1'b0;
         endcase
      end
   endfunction

   function is_legacy_op;
      input [7:0] op;
      begin
         case (op)
            `FPD_OP_READ_L, `FPD_OP_FREAD_L, `FPD_OP_QOREAD_L, `FPD_OP_QIOREAD_L,
            `FPD_OP_PPROG_L, `FPD_OP_QPROG_L, `FPD_OP_SERASE_L, `FPD_OP_BERASE_L,
            `FPD_OP_RDANY_L, `FPD_OP_WRANY_L: is_legacy_op = 1'b1;
            default: is_legacy_op = 1'b0;
         endcase
      end
   endfunction

   function is_read_op;
      input [7:0] op;
      begin
         case (op)
            `FPD_OP_READ_W, `FPD_OP_FREAD_W, `FPD_OP_QOREAD_W, `FPD_OP_QIOREAD_W,
            `FPD_OP_ECCREAD_W, `FPD_OP_READ_L, `FPD_OP_FREAD_L, `FPD_OP_QOREAD_L,
            `FPD_OP_QIOREAD_L, `FPD_OP_RDANY_L: is_read_op = 1'b1;
            default: is_read_op = 1'b0;
         endcase
      end
   endfunction

   function is_array_mod_op;
      input [7:0] op;
      begin
         case (op)
            `FPD_OP_PPROG_W, `FPD_OP_PSCRUB_W, `FPD_OP_QPROG_W, `FPD_OP_SERASE_W,
            `FPD_OP_BERASE_W, `FPD_OP_PPROG_L, `FPD_OP_QPROG_L, `FPD_OP_SERASE_L,
            `FPD_OP_BERASE_L: is_array_mod_op = 1'b1;
            default: is_array_mod_op = 1'b0;
         endcase
      end
   endfunction

   wire op_quad_addr = (opc_ff == `FPD_OP_QIOREAD_W) | (opc_ff == `FPD_OP_QIOREAD_L);
   wire op_quad_out  = op_quad_addr | (opc_ff == `FPD_OP_QOREAD_W) |
                       (opc_ff == `FPD_OP_QOREAD_L);
   wire op_quad_in   = (opc_ff == `FPD_OP_QPROG_W) | (opc_ff == `FPD_OP_QPROG_L);
   wire op_dummy     = op_quad_out | (opc_ff == `FPD_OP_FREAD_W) |
                       (opc_ff == `FPD_OP_FREAD_L);
   wire quad_step    = ((st_ff == ST_ADDR) & op_quad_addr) |
                       ((st_ff == ST_DIN) & op_quad_in);
   wire [5:0] step   = quad_step ? 6'd4 : 6'd1;
   wire [5:0] cnt_nxt = cnt_ff + step;
   wire [31:0] sh_nxt = quad_step ? {sh_ff[27:0], io_s} : {sh_ff[30:0], io_s[0]};
   // Wide opcodes always take 32 bits; legacy ones follow the mode bit
   wire [5:0] addr_bits = (wide_ff | alen_ff) ? `FPD_ADDR_BITS_4B
                                              : `FPD_ADDR_BITS_3B;
   // Short addresses must drop the opcode bits still held in the shifter
   wire [31:0] addr_cap = (addr_bits == `FPD_ADDR_BITS_4B) ? sh_nxt
                                                           : {8'h00, sh_nxt[23:0]};

   // Protected fraction is 1/2^(7-code) of the array for codes 1 to 7, none for code 0, in 1 MB granules
   wire [2:0] bp_code = {protect_range_bit2, protect_range_bit1, protect_range_bit0};
   wire [5:0] gran    = addr_ff[`FPD_ARRAY_MSB:`FPD_GRAN_LSB];
   wire [5:0] bp_mask = 6'h3f << (bp_code - 3'd1);
   wire in_top        = ((gran | ~bp_mask) == 6'h3f);
   wire in_bottom     = ((gran & bp_mask) == 6'h00);
   wire addr_prot     = (bp_code == 3'd7) |
                        ((bp_code != 3'd0) & (tb_ff ? in_bottom : in_top));

   wire                   buf_in_ready;
   wire [`FPD_REC_W-1:0] buf_out;

   fpd_buf2 #(
      .W (`FPD_REC_W)
   ) u_buf (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .in_data   (pend_rec_ff),
      .in_valid  (pend_ff),
      .in_ready  (buf_in_ready),
      .out_data  (buf_out),
      .out_valid (cmd_valid),
      .out_ready (cmd_ready)
   );

   assign cmd_read      = buf_out[`FPD_REC_READ_BIT];
   assign cmd_wide      = buf_out[`FPD_REC_WIDE_BIT];
   assign cmd_opcode    = buf_out[39:32];
   assign cmd_addr      = buf_out[31:0];
   assign io_out        = io_out_ff;
   assign io_oe         = io_oe_ff;
   assign rd_next       = rd_next_ff;
   assign prot_block    = prot_block_ff;
   assign frame_reject  = frame_reject_ff;
   assign config2_volatile        = {7'h00, alen_ff};
   assign protect_from_bottom_sel = tb_ff;
   assign protect_mode_selector   = spm_ff;

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_ff <= 6'h20;
         sync2_ff <= 6'h20;
         sck_d_ff <= 1'b0;
         cs_d_ff  <= 1'b1;
      end else begin
         sync1_ff <= {cs_n_pin, sck_pin, io_in};
         sync2_ff <= sync1_ff;
         sck_d_ff <= sck_s;
         cs_d_ff  <= cs_s;
      end
   end

   // Mode bits: alen_ff and spm_ff copies are sampled one edge after reset release and on sw_reset; tb_ff follows every edge
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         load_pend_ff <= 1'b1;
         alen_ff      <= 1'b0;
         spm_ff       <= 1'b0;
         tb_ff        <= 1'b0;
      end else begin
         load_pend_ff <= 1'b0;
         tb_ff        <= config1_nonvol[`FPD_CFG1NV_TB_BIT];
         if (load_pend_ff | sw_reset) begin
            alen_ff <= config2_nonvol[`FPD_CFG2NV_ALEN_BIT];
            spm_ff  <= status1_nonvol[`FPD_STAT1NV_SPM_BIT];
         end else if (cs_end & (bmod_ff == 3'd0) & (st_ff == ST_DIN)) begin
            if (opc_ff == `FPD_OP_ALEN_ENTER)
               alen_ff <= 1'b1;
            else if (opc_ff == `FPD_OP_ALEN_EXIT)
               alen_ff <= 1'b0;
         end
      end
   end

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff           <= ST_IDLE;
         opc_ff          <= 8'h00;
         sh_ff           <= 32'h0000_0000;
         addr_ff         <= 32'h0000_0000;
         cnt_ff          <= 6'd0;
         bmod_ff         <= 3'd0;
         addr_done_ff    <= 1'b0;
         wide_ff         <= 1'b0;
         out_sh_ff       <= 8'h00;
         out_cnt_ff      <= 3'd0;
         io_out_ff       <= 4'h0;
         io_oe_ff        <= 4'h0;
         rd_next_ff      <= 1'b0;
         prot_block_ff   <= 1'b0;
         frame_reject_ff <= 1'b0;
         pend_rec_ff     <= {`FPD_REC_W{1'b0}};
         pend_ff         <= 1'b0;
      end else begin
         rd_next_ff      <= 1'b0;
         prot_block_ff   <= 1'b0;
         frame_reject_ff <= 1'b0;
         if (pend_ff & buf_in_ready)
            pend_ff <= 1'b0;
         if (cs_end) begin
            // Select high ends the frame and releases the data lines
            st_ff    <= ST_IDLE;
            io_oe_ff <= 4'h0;
            if (bmod_ff != 3'd0 || st_ff == ST_OPC ||
                (st_ff == ST_ADDR && !addr_done_ff)) begin
               frame_reject_ff <= 1'b1;
            end else if (st_ff == ST_DIN) begin
               if (is_array_mod_op(opc_ff) & addr_prot) begin
                  prot_block_ff <= 1'b1;
               end else begin
                  pend_rec_ff <= {1'b0, wide_ff, opc_ff, addr_ff};
                  pend_ff     <= 1'b1;
               end
            end
         end else if (cs_start) begin
            st_ff        <= ST_OPC;
            cnt_ff       <= 6'd0;
            bmod_ff      <= 3'd0;
            addr_done_ff <= 1'b0;
            wide_ff      <= 1'b0;
            addr_ff      <= 32'h0000_0000;
         end else if (sck_rise) begin
            bmod_ff <= bmod_ff + step[2:0];
            sh_ff   <= sh_nxt;
            case (st_ff)
               ST_OPC: begin
                  cnt_ff <= cnt_nxt;
                  if (cnt_ff == 6'd7) begin
                     opc_ff  <= opc_nxt;
                     cnt_ff  <= 6'd0;
                     wide_ff <= is_wide_op(opc_nxt);
                     if (is_wide_op(opc_nxt) | is_legacy_op(opc_nxt))
                        st_ff <= ST_ADDR;
                     else
                        st_ff <= ST_DIN;
                  end
               end
               ST_ADDR: begin
                  cnt_ff <= cnt_nxt;
                  if (cnt_nxt == addr_bits) begin
                     addr_ff      <= addr_cap;
                     addr_done_ff <= 1'b1;
                     cnt_ff       <= 6'd0;
                     if (!is_read_op(opc_ff)) begin
                        st_ff <= ST_DIN;
                     end else begin
                        // Reads go to the array side as soon as the address is known
                        st_ff       <= op_dummy ? ST_DUMMY : ST_DOUT;
                        out_cnt_ff  <= 3'd0;
                        pend_rec_ff <= {1'b1, wide_ff, opc_ff, addr_cap};
                        pend_ff     <= 1'b1;
                     end
                  end
               end
               ST_DUMMY: begin
                  cnt_ff <= cnt_nxt;
                  if (cnt_nxt == `FPD_DUMMY_CYC)
                     st_ff <= ST_DOUT;
               end
               ST_DOUT, ST_DIN: begin
                  cnt_ff <= 6'd0;
               end
               default: st_ff <= ST_IDLE;
            endcase
         end else if (sck_fall & (st_ff == ST_DOUT)) begin
            // Data launches on the falling edge for the host to catch on the rise
            if (op_quad_out) begin
               io_oe_ff <= 4'hf;
               if (out_cnt_ff == 3'd0) begin
                  io_out_ff  <= rd_data[7:4];
                  out_sh_ff  <= {rd_data[3:0], 4'h0};
                  rd_next_ff <= 1'b1;
                  out_cnt_ff <= 3'd1;
               end else begin
                  io_out_ff  <= out_sh_ff[7:4];
                  out_cnt_ff <= 3'd0;
               end
            end else begin
               io_oe_ff <= 4'h2;
               if (out_cnt_ff == 3'd0) begin
                  io_out_ff  <= {2'b00, rd_data[7], 1'b0};
                  out_sh_ff  <= {rd_data[6:0], 1'b0};
                  rd_next_ff <= 1'b1;
               end else begin
                  io_out_ff <= {2'b00, out_sh_ff[7], 1'b0};
                  out_sh_ff <= {out_sh_ff[6:0], 1'b0};
               end
               out_cnt_ff <= out_cnt_ff + 3'd1;
            end
         end
      end
   end

endmodule // fpd_front

`default_nettype wire

//--- fpd_front_checker.sv
/* Port checker for fpd_front.
   Assumes it is bound into fpd_front and that everything runs on mclk. */
`timescale 1ns/100ps
`default_nettype none
module fpd_front_checker (
   input wire logic        mclk,
   input wire logic        arst_n,
   input wire logic        cs_n_pin,
   input wire logic [3:0]  io_oe,
   input wire logic        protect_range_bit2,
   input wire logic        protect_range_bit1,
   input wire logic        protect_range_bit0,
   input wire logic [7:0]  config1_nonvol,
   input wire logic [7:0]  config2_nonvol,
   input wire logic [7:0]  status1_nonvol,
   input wire logic        sw_reset,
   input wire logic [7:0]  config2_volatile,
   input wire logic        protect_from_bottom_sel,
   input wire logic        protect_mode_selector,
   input wire logic        cmd_valid,
   input wire logic        cmd_ready,
   input wire logic [7:0]  cmd_opcode,
   input wire logic [31:0] cmd_addr,
   input wire logic        cmd_wide,
   input wire logic        rd_next,
   input wire logic        prot_block,
   input wire logic        frame_reject
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   logic [3:0] hi_cnt_ff;
   // Saturates so a long idle stretch stays counted as idle
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) hi_cnt_ff <= 4'h0;
      else if (!cs_n_pin) hi_cnt_ff <= 4'h0;
      else if (hi_cnt_ff != 4'hf) hi_cnt_ff <= hi_cnt_ff + 4'h1;
   end
   a_tb_follow: assert property ($past(arst_n) |->
      protect_from_bottom_sel == $past(config1_nonvol[5])) else $error("tb select lag");
   a_boot_load: assert property ((!$past(arst_n) || $rose(sw_reset)) |-> ##2
      (config2_volatile[0] == config2_nonvol[1] && protect_mode_selector == status1_nonvol[7]))
      else $error("mode bits not reloaded");
   a_short_addr: assert property (cmd_valid && !cmd_wide && !config2_volatile[0] |->
      cmd_addr[31:24] == 8'h00) else $error("short address upper byte");
   a_pulse_once: assert property ((prot_block || frame_reject) |=>
      !(prot_block || frame_reject)) else $error("pulse too long");
   a_prot_code: assert property (prot_block |->
      {protect_range_bit2, protect_range_bit1, protect_range_bit0} != 3'b000)
      else $error("block with code zero");
   a_oe_legal: assert property (io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'hf)
      else $error("illegal enable");
   a_idle_quiet: assert property (hi_cnt_ff >= 4'h8 |-> io_oe == 4'h0 && !rd_next)
      else $error("drive while deselected");
   a_rec_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_opcode)
      && $stable(cmd_addr)) else $error("record dropped");
   a_wide_flag: assert property (cmd_valid |-> cmd_wide == (cmd_opcode inside {8'h13,
      8'h0c, 8'h6c, 8'hec, 8'h18, 8'h12, 8'hcf, 8'h34, 8'h21, 8'hdc})) else $error("wide flag");
   c_take: cover property (cmd_valid && cmd_ready);
   c_prot: cover property (prot_block);
   c_rej: cover property (frame_reject);
   c_quad: cover property (io_oe == 4'hf);
endmodule // fpd_front_checker
bind fpd_front fpd_front_checker u_chk (.mclk(mclk), .arst_n(arst_n), .cs_n_pin(cs_n_pin),
   .io_oe(io_oe), .protect_range_bit2(protect_range_bit2),
   .protect_range_bit1(protect_range_bit1), .protect_range_bit0(protect_range_bit0),
   .config1_nonvol(config1_nonvol), .config2_nonvol(config2_nonvol),
   .status1_nonvol(status1_nonvol), .sw_reset(sw_reset), .config2_volatile(config2_volatile),
   .protect_from_bottom_sel(protect_from_bottom_sel),
   .protect_mode_selector(protect_mode_selector), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
   .cmd_wide(cmd_wide), .rd_next(rd_next), .prot_block(prot_block),
   .frame_reject(frame_reject));
`default_nettype wire

//--- fpd_host_model.sv
/* Host serial controller model, mode 0, serial clock of 32 ns.
   Assumes mclk of 4 ns; all pin changes follow a falling mclk edge. */
`timescale 1ns/100ps
`default_nettype none
module fpd_host_model (
   input  wire logic       mclk,
   output logic            cs_n_pin,
   output logic            sck_pin,
   output logic [3:0]      io_in
);
   logic [3:0] host_val;
   logic [3:0] drv_mask;
   logic [3:0] junk;
   initial begin
      cs_n_pin = 1'b1;
      sck_pin = 1'b0;
      host_val = 4'h0;
      drv_mask = 4'h0;
      junk = 4'h5;
   end
   // Released lines toggle so a stale value never passes for data
   always @(negedge mclk) junk <= ~junk;
   assign io_in = (host_val & drv_mask) | (junk & ~drv_mask);
   task automatic start();
      repeat (1) @(negedge mclk);
      drv_mask = 4'h1;
      cs_n_pin = 1'b0;
      repeat (4) @(negedge mclk);
   endtask
   task automatic pulse();
      repeat (4) @(negedge mclk);
      sck_pin = 1'b1;
      repeat (4) @(negedge mclk);
      sck_pin = 1'b0;
   endtask
   task automatic shift(input logic [31:0] val, input int nbits, input int lanes);
      for (int i = nbits - lanes; i >= 0; i -= lanes) begin
         drv_mask = (lanes == 4) ? 4'hf : 4'h1;
         host_val = (lanes == 4) ? val[i +: 4] : {3'b000, val[i]};
         pulse();
      end
   endtask
   task automatic clocks(input int n, input logic [3:0] mask);
      drv_mask = mask;
      repeat (n) pulse();
   endtask
   task automatic stop();
      repeat (4) @(negedge mclk);
      cs_n_pin = 1'b1;
      drv_mask = 4'h0;
      repeat (8) @(negedge mclk);
   endtask
endmodule // fpd_host_model
`default_nettype wire

//--- fpd_front_test.sv
/* Self-checking bench for fpd_front with a scoreboard of command records.
   Assumes fpd_host_model drives the pins; inputs change on falling mclk. */
`timescale 1ns/100ps
`default_nettype none
module fpd_front_test;
   logic        mclk, arst_n, sw_reset, cmd_ready, stall, alen, qrd;
   logic [2:0]  code;
   logic [7:0]  cfg1, cfg2, st1, rd_data, rd_q;
   logic [31:0] rv;
   wire         cs_n, sck, rd_next, pblk, frej, tbsel, pms, cvld, crd, cwd;
   wire  [3:0]  io_in, io_out, io_oe;
   wire  [7:0]  cfg2v, opc;
   wire  [31:0] caddr;
   logic [41:0] eq[$];
   logic [7:0]  lg[10] = '{8'h03, 8'h0b, 8'h6b, 8'heb, 8'h02, 8'h32, 8'h20, 8'hd8, 8'h65, 8'h71};
   logic [7:0]  wd[10] = '{8'h13, 8'h0c, 8'h6c, 8'hec, 8'h18, 8'h12, 8'hcf, 8'h34, 8'h21, 8'hdc};
   int          n_errors, compares, n_prot, n_rej, n, s;
   int          seed = 32'ha7cd;
   fpd_host_model host (.mclk(mclk), .cs_n_pin(cs_n), .sck_pin(sck), .io_in(io_in));
   fpd_front uut (.mclk(mclk), .arst_n(arst_n), .cs_n_pin(cs_n), .sck_pin(sck),
      .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .protect_range_bit2(code[2]),
      .protect_range_bit1(code[1]), .protect_range_bit0(code[0]), .config1_nonvol(cfg1),
      .config2_nonvol(cfg2), .status1_nonvol(st1), .sw_reset(sw_reset),
      .config2_volatile(cfg2v), .protect_from_bottom_sel(tbsel), .protect_mode_selector(pms),
      .cmd_valid(cvld), .cmd_ready(cmd_ready), .cmd_opcode(opc), .cmd_addr(caddr),
      .cmd_read(crd), .cmd_wide(cwd), .rd_data(rd_data), .rd_next(rd_next),
      .prot_block(pblk), .frame_reject(frej));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(negedge mclk) begin
      rv = $random(seed);
      rd_data <= rv[7:0];
      cmd_ready <= !stall && rv[8];
   end
   task automatic check(input string what, input logic [41:0] seen, input logic [41:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   always @(posedge mclk) begin
      if (pblk === 1'b1) n_prot++;
      // rd_q holds the byte the design took at the edge that raised rd_next
      rd_q <= rd_data;
      if (rd_next === 1'b1)
         check("io_out", 42'(io_out), qrd ? 42'(rd_q[7:4]) : 42'({rd_q[7], 1'b0}));
      if (frej === 1'b1) n_rej++;
      if (cvld === 1'b1 && cmd_ready === 1'b1)
         check("record", {opc, caddr, crd, cwd}, eq.size() ? eq.pop_front() : 42'h0);
   end
   function automatic logic prot_hit(input logic [31:0] a);
      int k;
      k = (code == 0) ? 0 : (code == 7) ? 64 : (1 << (code - 1));
      return cfg1[5] ? (int'(a[25:20]) < k) : (int'(a[25:20]) >= 64 - k);
   endfunction
   function automatic logic [31:0] rnd_addr();
      logic [31:0] r;
      r = $random(seed);
      return {6'h00, r[25:0]};
   endfunction
   task automatic cmd(input logic [7:0] op, input logic [31:0] a);
      logic w, rd, qd, hit;
      int   ab, p0;
      w  = op inside {8'h13, 8'h0c, 8'h6c, 8'hec, 8'h18, 8'h12, 8'hcf, 8'h34, 8'h21, 8'hdc};
      rd = op inside {8'h03, 8'h0b, 8'h6b, 8'heb, 8'h65, 8'h13, 8'h0c, 8'h6c, 8'hec, 8'h18};
      qd = op inside {8'h6b, 8'h6c, 8'heb, 8'hec};
      qrd = qd;
      ab = (op inside {8'hb7, 8'he9}) ? 0 : (w || alen) ? 32 : 24;
      if (ab != 32) a[31:24] = 8'h00;
      if (ab == 0) a = 32'h0;
      hit = !rd && ab != 0 && op != 8'h71 && prot_hit(a);
      p0 = n_prot;
      if (!hit) eq.push_back({op, a, rd, w});
      host.start();
      host.shift({24'h0, op}, 8, 1);
      host.shift(a, ab, (op inside {8'heb, 8'hec}) ? 4 : 1);
      if (rd) begin
         host.clocks((qd || op inside {8'h0b, 8'h0c}) ? 9 : 1, qd ? 4'h0 : 4'h1);
         check("io_oe", 42'(io_oe), qd ? 42'hf : 42'h2);
         host.clocks(7, qd ? 4'h0 : 4'h1);
      end
      host.stop();
      repeat (4) @(negedge mclk);
      check("prot_block", 42'(n_prot - p0), 42'(hit));
   endtask
   task automatic bad(input int nb);
      int r0;
      r0 = n_rej;
      host.start();
      host.shift({24'h0, 8'h20}, 8, 1);
      host.shift(32'h5a5, nb, 1);
      host.stop();
      repeat (4) @(negedge mclk);
      check("frame_reject", 42'(n_rej - r0), 42'h1);
   endtask
   task automatic close_out();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #300000;
      n_errors++;
      close_out();
   end
   initial begin
      arst_n = 1'b0;
      {sw_reset, stall, alen, code} = 6'h00;
      {cfg1, cfg2, st1} = 24'h0;
      repeat (4) @(posedge mclk);
      @(negedge mclk) arst_n = 1'b1;
      repeat (8) @(negedge mclk);
      check("alen", 42'(cfg2v), 42'h0);
      foreach (lg[i]) cmd(lg[i], rnd_addr());
      foreach (wd[i]) cmd(wd[i], rnd_addr());
      cfg2 = 8'h02;
      st1 = 8'h80;
      sw_reset = 1'b1;
      @(negedge mclk) sw_reset = 1'b0;
      repeat (3) @(negedge mclk);
      alen = 1'b1;
      check("alen", 42'(cfg2v), 42'h1);
      check("mode_sel", 42'(pms), 42'h1);
      foreach (lg[i]) cmd(lg[i], rnd_addr());
      cmd(8'he9, 32'h0);
      alen = 1'b0;
      check("alen", 42'(cfg2v), 42'h0);
      cmd(8'h03, rnd_addr());
      cmd(8'hb7, 32'h0);
      alen = 1'b1;
      check("alen", 42'(cfg2v), 42'h1);
      cmd(8'h20, rnd_addr());
      // Boundary sectors on both sides of each protected region
      for (int t = 0; t < 2; t++) begin
         for (int c = 0; c < 8; c++) begin
            @(negedge mclk);
            cfg1 = {2'b00, t[0], 5'h0a};
            code = c[2:0];
            repeat (2) @(negedge mclk);
            check("tb_sel", 42'(tbsel), 42'(t));
            n = (c == 0) ? 0 : (c == 7) ? 64 : (1 << (c - 1));
            s = t ? n : 64 - n;
            cmd(8'h21, {6'h00, 6'(s), 20'h00000});
            cmd(8'hdc, {6'h00, 6'(s - 1), 20'hfffff});
         end
      end
      code = 3'h0;
      bad(4);
      bad(8);
      // Three records with the receiver stalled: two in the entries, one in the output register
      stall = 1'b1;
      repeat (3) cmd(8'h20, rnd_addr());
      check("cmd_valid", 42'(cvld), 42'h1);
      stall = 1'b0;
      for (int i = 0; i < 400 && eq.size() > 0; i++) @(negedge mclk);
      check("left", 42'(eq.size()), 42'h0);
      close_out();
   end
endmodule // fpd_front_test
`default_nettype wire
